// [pkg/increment_or_move_consts.svh]
// Named constants for the increment, OR and move execution block.
// Assumes 14-bit instruction words and 8-bit data.
`ifndef INCREMENT_OR_MOVE_CONSTS_SVH
`define INCREMENT_OR_MOVE_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------------
`define OPC_HI 13
`define OPC_LO 8
`define DEST_BIT 7
`define FADDR_HI 6
`define LIT_HI 7

// ----------------------------------------------------------------------
// Opcode field values
// ----------------------------------------------------------------------
`define OPC_INCREMENT_FILE 6'h0a
`define OPC_OR_LITERAL 6'h38
`define OPC_OR_FILE 6'h04
`define OPC_MOVE_FILE 6'h08

// ----------------------------------------------------------------------
// Reset values and arithmetic
// ----------------------------------------------------------------------
`define ACC_RESET 8'h00
`define ZERO_RESET 1'b0
`define FILE_RESET 8'h00
`define INC_STEP 8'h01

`endif

// [pkg/increment_or_move_pkg.sv]
// Types shared by the decoder, its interface and the execution block.
// Assumes nothing of its surroundings.
package increment_or_move_pkg;

  // ----------------------------------------------------------------------
  // Decoded operation
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_increment_file = 3'b001,
    op_or_literal_into_accumulator = 3'b010,
    op_or_accumulator_with_file = 3'b011,
    op_move_file = 3'b100
  } op_e;

endpackage : increment_or_move_pkg

// [pkg/decode_if.sv]
// Carrier between the instruction decoder and the execution block.
// Assumes both ends share one clock domain; it holds no state.
`timescale 1ns/1ns
`default_nettype none

interface decode_if;
  logic [13:0] word;
  increment_or_move_pkg::op_e op;
  logic dest_file;
  logic [6:0] faddr;
  logic [7:0] literal;

  modport decoder (input word, output op, output dest_file, output faddr,
    output literal);
  modport exec (output word, input op, input dest_file, input faddr,
    input literal);
endinterface : decode_if

`default_nettype wire

// [hw/instr_field_decoder.sv]
// Combinational decoder of one 14-bit instruction word.
// Assumes the word is held stable by fetch; the execution block passes instr_word_in through unregistered.
`timescale 1ns/1ns
`default_nettype none
`include "increment_or_move_consts.svh"

module instr_field_decoder (
  decode_if.decoder dec
);

  // ----------------------------------------------------------------------
  // Field extraction and opcode match
  // ----------------------------------------------------------------------
  always_comb begin
    dec.dest_file = dec.word[`DEST_BIT];
    dec.faddr = dec.word[`FADDR_HI:0];
    dec.literal = dec.word[`LIT_HI:0];
    unique case (dec.word[`OPC_HI:`OPC_LO])
      `OPC_INCREMENT_FILE: dec.op = increment_or_move_pkg::op_increment_file;
      `OPC_OR_LITERAL: begin
        dec.op = increment_or_move_pkg::op_or_literal_into_accumulator;
      end
      `OPC_OR_FILE: begin
        dec.op = increment_or_move_pkg::op_or_accumulator_with_file;
      end
      `OPC_MOVE_FILE: dec.op = increment_or_move_pkg::op_move_file;
      default: dec.op = increment_or_move_pkg::op_none;
    endcase
  end

endmodule : instr_field_decoder

`default_nettype wire

// [hw/increment_or_move_exec.sv]
// Execution of increment, OR and move instructions on an 8-bit core.
// Assumes synchronous inputs on sys_clk_in and holds its own file registers.
// Assumes the host load and peek ports serve only to set and observe state.
`timescale 1ns/1ns
`default_nettype none
`include "increment_or_move_consts.svh"

module increment_or_move_exec #(
  parameter int FILE_DEPTH = 128,
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // Clock, reset and clock enable
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Instruction from fetch
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_word_in,
  // Direct file register load
  input wire logic host_wr_en_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [DATA_W-1:0] host_wr_data_in,
  // File register observation
  input wire logic [ADDR_W-1:0] peek_addr_in,
  output logic [DATA_W-1:0] peek_data_out,
  // Core state
  output logic [DATA_W-1:0] accumulator_out,
  output logic zero_flag_out,
  output logic [DATA_W-1:0] result_out,
  output logic retired_out,
  output logic unsupported_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    is_zero = (value == '0);
  endfunction : is_zero

  // ----------------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------------
  decode_if dec ();

  assign dec.word = instr_word_in;

  instr_field_decoder u_decoder (
    .dec(dec)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] file_q [FILE_DEPTH];
  logic [DATA_W-1:0] file_d [FILE_DEPTH];
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  logic zero_q;
  logic zero_d;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] result_d;
  logic retired_q;
  logic retired_d;
  logic unsup_q;
  logic unsup_d;
  logic [DATA_W-1:0] peek_q;
  logic [DATA_W-1:0] peek_d;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] res;
  logic executes;
  logic routed;
  logic take;
  logic write_file;
  logic write_acc;

  // ----------------------------------------------------------------------
  // Operand read and arithmetic
  // ----------------------------------------------------------------------
  always_comb begin
    operand = file_q[dec.faddr];
    res = operand;
    executes = 1'b1;
    routed = 1'b1;
    unique case (dec.op)
      increment_or_move_pkg::op_increment_file: begin
        res = operand + `INC_STEP;
      end
      increment_or_move_pkg::op_or_literal_into_accumulator: begin
        res = acc_q | dec.literal;
        routed = 1'b0;
      end
      increment_or_move_pkg::op_or_accumulator_with_file: begin
        res = acc_q | operand;
      end
      increment_or_move_pkg::op_move_file: begin
        res = operand;
      end
      increment_or_move_pkg::op_none: begin
        executes = 1'b0;
        routed = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Routing of an executed instruction
  // ----------------------------------------------------------------------
  always_comb begin
    take = instr_valid_in && executes;
    write_file = 1'h0;
    write_acc = 1'h0;
    if (take) begin
      write_file = routed && dec.dest_file;
      write_acc = !(routed && dec.dest_file);
    end
  end

  // ----------------------------------------------------------------------
  // File registers
  // ----------------------------------------------------------------------
  always_comb begin
    file_d = file_q;
    if (host_wr_en_in) begin
      file_d[host_addr_in] = host_wr_data_in;
    end
    if (write_file) begin
      file_d[dec.faddr] = res;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= `FILE_RESET;
      end
    end else if (clk_en_in) begin
      file_q <= file_d;
    end
  end

  // ----------------------------------------------------------------------
  // Accumulator, zero flag and result
  // ----------------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    result_d = result_q;
    if (take) begin
      result_d = res;
      zero_d = is_zero(res);
    end
    if (write_acc) begin
      acc_d = res;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_q <= `ACC_RESET;
      zero_q <= `ZERO_RESET;
      result_q <= `ACC_RESET;
    end else if (clk_en_in) begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction pulses
  // ----------------------------------------------------------------------
  always_comb begin
    retired_d = take;
    unsup_d = instr_valid_in && !executes;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      retired_q <= 1'h0;
      unsup_q <= 1'h0;
    end else if (clk_en_in) begin
      retired_q <= retired_d;
      unsup_q <= unsup_d;
    end
  end

  // ----------------------------------------------------------------------
  // Observation port
  // ----------------------------------------------------------------------
  always_comb begin
    peek_d = file_q[peek_addr_in];
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      peek_q <= `FILE_RESET;
    end else if (clk_en_in) begin
      peek_q <= peek_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign accumulator_out = acc_q;
  assign zero_flag_out = zero_q;
  assign result_out = result_q;
  assign retired_out = retired_q;
  assign unsupported_out = unsup_q;
  assign peek_data_out = peek_q;

endmodule : increment_or_move_exec

`default_nettype wire

// [test/increment_or_move_checker.sv]
// Port assertions for the execution block.
// Assumes binding onto increment_or_move_exec, peek port shows old values.
`timescale 1ns/1ns
`default_nettype none
`include "increment_or_move_consts.svh"
module increment_or_move_checker (
  // Clock, reset and controls
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_word_in,
  input wire logic [6:0] peek_addr_in,
  // Outputs
  input wire logic [7:0] peek_data_out,
  input wire logic [7:0] accumulator_out,
  input wire logic zero_flag_out,
  input wire logic [7:0] result_out,
  input wire logic retired_out
);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic tk, hit, fop;
  logic [5:0] opc;
  assign opc = instr_word_in[13:8];
  assign tk = clk_en_in && instr_valid_in;
  assign hit = peek_addr_in == instr_word_in[6:0];
  assign fop = opc inside {6'h0a, 6'h04, 6'h08};
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence move_self;
    tk && opc == `OPC_MOVE_FILE && instr_word_in[7] && hit
      ##1 clk_en_in && $stable(peek_addr_in);
  endsequence
  AST_INC: assert property (tk && opc == `OPC_INCREMENT_FILE && hit
    |=> result_out == peek_data_out + 8'h01
    && zero_flag_out == (result_out == 8'h00)) else $error("bad increment");
  AST_TO_ACC: assert property (tk && fop && !instr_word_in[7]
    |=> accumulator_out == result_out) else $error("bad acc dest");
  AST_TO_FILE: assert property (tk && fop && instr_word_in[7]
    |=> $stable(accumulator_out) && retired_out) else $error("bad file dest");
  AST_OR_LIT: assert property (tk && opc == `OPC_OR_LITERAL
    |=> accumulator_out == ($past(accumulator_out) | $past(instr_word_in[7:0]))
    && zero_flag_out == (accumulator_out == 8'h00)) else $error("bad or lit");
  AST_MOVE: assert property (tk && opc == `OPC_MOVE_FILE && hit
    |=> result_out == peek_data_out
    && zero_flag_out == (peek_data_out == 8'h00)) else $error("bad move");
  AST_MOVE_KEEP: assert property (move_self
    |=> peek_data_out == $past(peek_data_out)) else $error("move changed f");
  AST_OR_FILE: assert property (tk && opc == `OPC_OR_FILE && hit
    |=> retired_out && result_out == (peek_data_out | $past(accumulator_out)))
    else $error("bad or file");
endmodule : increment_or_move_checker
bind increment_or_move_exec increment_or_move_checker chk (.sys_clk_in,
  .nrst_in, .clk_en_in, .instr_valid_in, .instr_word_in, .peek_addr_in,
  .peek_data_out, .accumulator_out, .zero_flag_out, .result_out, .retired_out);
`default_nettype wire

// [test/tb.sv]
// Self-checking bench of the execution block with a reference model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
`default_nettype none
`include "increment_or_move_consts.svh"
module tb;
  // ----------------------------------------------------------------------
  // Stimulus, model and checks
  // ----------------------------------------------------------------------
  logic sys_clk_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b0;
  logic instr_valid_in = 1'b0, host_wr_en_in = 1'b0;
  logic [13:0] instr_word_in = 14'h0000;
  logic [6:0] host_addr_in = 7'h00, peek_addr_in = 7'h00;
  logic [7:0] host_wr_data_in = 8'h00, peek_data_out, accumulator_out;
  logic [7:0] result_out, acc = 8'h00, res = 8'h00, pk = 8'h00, lw;
  logic zero_flag_out, retired_out, unsupported_out, z = 0, ret = 0, uns = 0;
  logic [7:0] f [128];
  logic [5:0] o, ops [5] = '{6'h0a, 6'h38, 6'h04, 6'h08, 6'h15};
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  increment_or_move_exec uut (.sys_clk_in, .nrst_in, .clk_en_in,
    .instr_valid_in, .instr_word_in, .host_wr_en_in, .host_addr_in,
    .host_wr_data_in, .peek_addr_in, .peek_data_out, .accumulator_out,
    .zero_flag_out, .result_out, .retired_out, .unsupported_out);
  function automatic logic [7:0] calc(logic [5:0] c, logic [7:0] a, v, k);
    case (c)
      `OPC_INCREMENT_FILE: return v + 8'h01;
      `OPC_OR_LITERAL: return a | k;
      `OPC_OR_FILE: return a | v;
      default: return v;
    endcase
  endfunction : calc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic step(logic en, v, logic [13:0] w, logic hw, logic [6:0] ha,
    logic [7:0] hd);
    @(negedge sys_clk_in);
    check(accumulator_out, acc);
    check(8'(zero_flag_out), 8'(z));
    check(result_out, res);
    check(8'(retired_out), 8'(ret));
    check(8'(unsupported_out), 8'(uns));
    check(peek_data_out, pk);
    clk_en_in = en;
    instr_valid_in = v;
    instr_word_in = w;
    host_wr_en_in = hw;
    host_addr_in = ha;
    host_wr_data_in = hd;
    peek_addr_in = w[6:0];
    @(posedge sys_clk_in);
    if (en) begin
      pk = f[w[6:0]];
      if (hw) f[ha] = hd;
      ret = v && w[13:8] inside {6'h0a, 6'h38, 6'h04, 6'h08};
      uns = v && !ret;
      if (ret) begin
        res = calc(w[13:8], acc, pk, w[7:0]);
        z = res == 8'h00;
        if (w[13:8] == `OPC_OR_LITERAL || !w[7]) acc = res;
        else f[w[6:0]] = res;
      end
    end
  endtask : step
  initial begin
    f = '{default: 8'h00};
    void'($urandom(32'ha679));
    repeat (10) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    step(1, 0, 14'h0000, 1, 7'h05, 8'hff);
    step(1, 1, 14'h0a85, 0, 7'h00, 8'h00);
    step(1, 1, 14'h0885, 1, 7'h06, 8'h9a);
    step(1, 1, 14'h0885, 1, 7'h05, 8'h13);
    step(1, 1, 14'h0806, 0, 7'h00, 8'h00);
    step(1, 1, 14'h3835, 1, 7'h07, 8'h13);
    step(1, 1, 14'h0a07, 0, 7'h00, 8'h00);
    step(1, 1, 14'h0487, 0, 7'h00, 8'h00);
    step(1, 1, 14'h3fff, 0, 7'h00, 8'h00);
    step(0, 1, 14'h0a07, 0, 7'h00, 8'h00);
    repeat (2000) begin
      o = ops[$urandom % 5];
      lw = 8'($urandom);
      step($urandom % 8 != 0, $urandom % 4 != 0,
        {o, (o == `OPC_OR_LITERAL) ? lw : (lw & 8'h87)},
        $urandom % 4 == 0, 7'($urandom % 8), 8'($urandom));
    end
    step(1, 0, 14'h0000, 0, 7'h00, 8'h00);
    @(negedge sys_clk_in);
    nrst_in = 1'b0;
    f = '{default: 8'h00};
    acc = 8'h00;
    res = 8'h00;
    pk = 8'h00;
    z = 1'b0;
    ret = 1'b0;
    uns = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    step(1, 1, 14'h0885, 0, 7'h00, 8'h00);
    step(1, 1, 14'h3800, 0, 7'h00, 8'h00);
    step(1, 0, 14'h0000, 0, 7'h00, 8'h00);
    give_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
